// ---- lpcc_pkg.sv ----
/*
 Package for the line printer channel controller: bus offsets, register fields,
 instruction address fields, format code fields and timing counts.
 Assumes a 40 MHz system clock and a classic Wishbone register bus.
*/
package lpcc_pkg;

	localparam logic [7:0] LPCC_OFF_INSTR   = 8'h00;
	localparam logic [7:0] LPCC_OFF_DATA    = 8'h04;
	localparam logic [7:0] LPCC_OFF_STATUS  = 8'h08;
	localparam logic [7:0] LPCC_OFF_CONFIG  = 8'h0c;
	localparam logic [7:0] LPCC_OFF_PRINTED = 8'h10;

	localparam int LPCC_INS_FUNC_BIT  = 16;
	localparam int LPCC_INS_TEST_BIT  = 17;
	localparam int LPCC_INS_C_BIT     = 15;
	localparam int LPCC_INS_K_LSB     = 12;
	localparam int LPCC_INS_D_LSB     = 8;

	localparam int LPCC_SF_INTEN_BIT  = 7;
	localparam int LPCC_SF_ADV_BIT    = 6;
	localparam int LPCC_SF_COUNT_BIT  = 3;

	localparam int LPCC_TS_ADV_BIT    = 4;
	localparam int LPCC_TS_FULL_BIT   = 3;
	localparam int LPCC_TS_READY_BIT  = 2;
	localparam int LPCC_TS_NLR_BIT    = 1;
	localparam int LPCC_TS_SEND_BIT   = 0;

	localparam logic [6:0] LPCC_EOL_CODE  = 7'o155;
	localparam int LPCC_FMT_MODE_BIT      = 4;
	localparam int LPCC_LINE_CHARS        = 136;

	localparam int LPCC_CLK_MHZ           = 40;
	localparam int LPCC_LINE_STEP_US      = 10;
	localparam int LPCC_PRINT_US          = 50;
	localparam int LPCC_LINE_STEP_CYC     = LPCC_LINE_STEP_US * LPCC_CLK_MHZ;
	localparam int LPCC_PRINT_CYC         = LPCC_PRINT_US * LPCC_CLK_MHZ;

	localparam logic [3:0] LPCC_RST_DEV   = 4'h1;
	localparam logic [2:0] LPCC_RST_CHAN  = 3'h0;

	typedef enum logic [1:0] {
		LPCC_IDLE  = 2'b00,
		LPCC_FMT   = 2'b01,
		LPCC_DATA  = 2'b10,
		LPCC_PRINT = 2'b11
	} lpcc_state_e;

endpackage

// ---- lpcc_ctrl.sv ----
/*
 Line printer channel controller: Wishbone register slave, instruction decode,
 channel byte receiver with parity check, one-line buffer, format and print sequencer.
 Assumes printer mechanism inputs are asynchronous pins and the bus is on clk_sys_in.
*/
`timescale 1ns/1ps

// What this block does
// - Odd parity checked; bad characters flagged, never printed.
// - Byte mode; six low bits print.
// - Octal 155 ends line, starts printing.
// - First line character is format, not stored.
// - Accept data during advance; print after.
// - After spacing instruction, discard next first character.
// - No-advance instruction also discards next first.
// - Count mode advances zero to seven lines.
// - Tape mode advances to selected tape channel.
// - Bit 3 (spacing) or bit 4 (format) picks mode; low three bits value.
// - Buffer 136 characters; flag overflow beyond.
// - Not ready refuses connection and data.
// - Line request after print, and on clear.
// - Character request only when accepting; not printing.
// - Advancing indicator true while paper moves.
// - Enabled interrupt on line request; connect/clear resets.
// - Interrupt enable refused while any device connected.
// - Test result equals addressed indicator.
// - Spacing refused busy during spacing or print.
// - Connect refused only when not ready.
// - After connect, data waits for line request.
// - Answer only matching channel and device; clear acts only on non-matching ones.
module lpcc_ctrl
	import lpcc_pkg::*;
#(
	parameter int LINE_CHARS   = LPCC_LINE_CHARS,
	parameter int STEP_CYCLES  = LPCC_LINE_STEP_CYC,
	parameter int PRINT_CYCLES = LPCC_PRINT_CYC
)
(
	// Clock and reset.
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// Wishbone slave.
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [7:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	// Printer mechanism pins.
	input  wire logic        mech_ready_in,
	input  wire logic [7:0]  form_tape_in,
	input  wire logic        other_connected_in,
	// Channel status to processor.
	output logic             chan_parity_out,
	output logic             chan_irq_out,
	output logic             busy_out,
	output logic             test_result_out,
	// Printer hammer side.
	output logic             hammer_fire_out,
	output logic             paper_step_out
);

	localparam int PW = $clog2(LINE_CHARS + 1);
	localparam int TW = $clog2(PRINT_CYCLES + STEP_CYCLES + 1);

	logic [5:0] line_mem [LINE_CHARS];

	logic        rdy_m_q, rdy_q;
	logic [7:0]  tape_m_q, tape_q;
	logic        rdy_d;
	logic [7:0]  tape_d;

	lpcc_state_e st_q, st_d;
	logic [PW-1:0] ptr_q, ptr_d;
	logic [TW-1:0] tmr_q, tmr_d;
	logic [TW-1:0] ptmr_q, ptmr_d;
	logic [2:0]  lines_q, lines_d;
	logic [2:0]  tchan_q, tchan_d;
	logic        tmode_q, tmode_d;
	logic        adv_q, adv_d;
	logic        skip_q, skip_d;
	logic        conn_q, conn_d;
	logic        nlr_q, nlr_d;
	logic        ien_q, ien_d;
	logic        ovf_q, ovf_d;
	logic        par_q, par_d;
	logic        irq_q, irq_d;
	logic        busy_q, busy_d;
	logic        tres_q, tres_d;
	logic        ham_q, ham_d;
	logic        step_q, step_d;
	logic        ack_q, ack_d;
	logic [31:0] rd_q, rd_d;
	logic [2:0]  chan_q, chan_d;
	logic [3:0]  dev_q, dev_d;
	logic [15:0] prcnt_q, prcnt_d;

	logic        wr, rd, hit, sendreq, parity_ok;
	logic [7:0]  ch;
	logic [6:0]  ch7;

	assign wr  = wb_cyc_in && wb_stb_in && wb_we_in && !ack_q && wb_sel_in[0];
	assign rd  = wb_cyc_in && wb_stb_in && !wb_we_in && !ack_q;
	assign ch  = wb_dat_in[7:0];
	assign ch7 = ch[6:0];
	assign parity_ok = ^ch;
	assign hit = wb_dat_in[LPCC_INS_K_LSB +: 3] == chan_q && wb_dat_in[LPCC_INS_D_LSB +: 4] == dev_q;
	assign sendreq = rdy_q && conn_q && nlr_q && st_q != LPCC_PRINT;

	always_comb
	begin
		rdy_d  = rdy_m_q;
		tape_d = tape_m_q;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			rdy_m_q  <= 1'b0;
			rdy_q    <= 1'b0;
			tape_m_q <= 8'h00;
			tape_q   <= 8'h00;
		end
		else
		begin
			rdy_m_q  <= mech_ready_in;
			rdy_q    <= rdy_d;
			tape_m_q <= form_tape_in;
			tape_q   <= tape_d;
		end
	end

	always_comb
	begin
		st_d = st_q;
		ptr_d = ptr_q;
		tmr_d = tmr_q;
		ptmr_d = ptmr_q;
		lines_d = lines_q;
		tchan_d = tchan_q;
		tmode_d = tmode_q;
		adv_d = adv_q;
		skip_d = skip_q;
		conn_d = conn_q;
		nlr_d = nlr_q;
		ien_d = ien_q;
		ovf_d = ovf_q;
		par_d = par_q;
		irq_d = 1'b0;
		busy_d = busy_q;
		tres_d = tres_q;
		ham_d = 1'b0;
		step_d = 1'b0;
		ack_d = 1'b0;
		rd_d = rd_q;
		chan_d = chan_q;
		dev_d = dev_q;
		prcnt_d = prcnt_q;
		if (adv_q)
		begin
			if (tmr_q != '0)
				tmr_d = tmr_q - 1'b1;
			else if (tmode_q)
			begin
				if (tape_q[tchan_q])
					adv_d = 1'b0;
				else
				begin
					step_d = 1'b1;
					tmr_d = TW'(STEP_CYCLES);
				end
			end
			else if (lines_q != 3'h0)
			begin
				step_d = 1'b1;
				lines_d = lines_q - 3'h1;
				tmr_d = TW'(STEP_CYCLES);
			end
			else
				adv_d = 1'b0;
		end
		if (st_q == LPCC_PRINT && !adv_q)
		begin
			if (ptmr_q != '0)
				ptmr_d = ptmr_q - 1'b1;
			else
			begin
				ham_d = 1'b1;
				prcnt_d = prcnt_q + 16'h0001;
				st_d = LPCC_IDLE;
				ptr_d = '0;
				nlr_d = rdy_q;
				irq_d = ien_q && rdy_q;
			end
		end
		if (!rdy_q)
			conn_d = 1'b0;
		if (wb_cyc_in && wb_stb_in && !ack_q)
			ack_d = 1'b1;
		if (rd)
		begin
			case (wb_adr_in)
				LPCC_OFF_STATUS:  rd_d = {22'h0, busy_q, tres_q, ien_q, conn_q, par_q, ovf_q,
					adv_q, st_q == LPCC_PRINT, rdy_q, nlr_q};
				LPCC_OFF_CONFIG:  rd_d = {25'h0, chan_q, dev_q};
				LPCC_OFF_PRINTED: rd_d = {16'h0, prcnt_q};
				default:          rd_d = 32'h0;
			endcase
		end
		if (wr && wb_adr_in == LPCC_OFF_CONFIG)
		begin
			dev_d = ch[3:0];
			chan_d = ch[6:4];
			if (ch[7])
				par_d = 1'b0;
		end
		if (wr && wb_adr_in == LPCC_OFF_INSTR && hit)
		begin
			busy_d = 1'b0;
			if (wb_dat_in[LPCC_INS_TEST_BIT])
				tres_d = (ch[LPCC_TS_ADV_BIT] && adv_q) || (ch[LPCC_TS_FULL_BIT] && ptr_q == PW'(LINE_CHARS))
					|| (ch[LPCC_TS_READY_BIT] && rdy_q) || (ch[LPCC_TS_NLR_BIT] && nlr_q)
					|| (ch[LPCC_TS_SEND_BIT] && sendreq);
			else if (wb_dat_in[LPCC_INS_C_BIT])
			begin
				if (!rdy_q)
					busy_d = 1'b1;
				else
				begin
					conn_d = 1'b1;
					ien_d = 1'b0;
					par_d = 1'b0;
					ovf_d = 1'b0;
					if (st_q == LPCC_IDLE && !adv_q)
						nlr_d = 1'b1;
				end
			end
			else if (ch[LPCC_SF_INTEN_BIT])
			begin
				if (other_connected_in || conn_q)
					busy_d = 1'b1;
				else
					ien_d = 1'b1;
			end
			else if (adv_q || st_q == LPCC_PRINT)
				busy_d = 1'b1;
			else
			begin
				skip_d = 1'b1;
				if (ch[LPCC_SF_ADV_BIT])
				begin
					adv_d = 1'b1;
					tmr_d = '0;
					tmode_d = !ch[LPCC_SF_COUNT_BIT];
					lines_d = ch[2:0];
					tchan_d = ch[2:0];
				end
			end
		end
		if (wr && wb_adr_in == LPCC_OFF_INSTR && !hit && wb_dat_in[LPCC_INS_C_BIT] && wb_dat_in[LPCC_INS_FUNC_BIT])
		begin
			conn_d = 1'b0;
			ien_d = 1'b0;
			nlr_d = rdy_q;
			par_d = 1'b0;
		end
		if (wr && wb_adr_in == LPCC_OFF_DATA && sendreq)
		begin
			if (!parity_ok)
				par_d = 1'b1;
			else if (st_q == LPCC_IDLE || st_q == LPCC_FMT)
			begin
				st_d = LPCC_DATA;
				if (skip_q)
					skip_d = 1'b0;
				else if (!adv_q)
				begin
					adv_d = 1'b1;
					tmr_d = '0;
					tmode_d = !ch[LPCC_FMT_MODE_BIT];
					lines_d = ch[2:0];
					tchan_d = ch[2:0];
				end
			end
			else if (ch7 == LPCC_EOL_CODE)
			begin
				st_d = LPCC_PRINT;
				ptmr_d = TW'(PRINT_CYCLES);
				nlr_d = 1'b0;
			end
			else if (ptr_q == PW'(LINE_CHARS))
				ovf_d = 1'b1;
			else
				ptr_d = ptr_q + 1'b1;
		end
		if (!conn_q && st_q == LPCC_IDLE)
			st_d = LPCC_IDLE;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (wr && wb_adr_in == LPCC_OFF_DATA && sendreq && parity_ok && st_q == LPCC_DATA
			&& ch7 != LPCC_EOL_CODE && ptr_q != PW'(LINE_CHARS))
			line_mem[ptr_q] <= ch[5:0];
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			st_q <= LPCC_IDLE;
			ptr_q <= '0;
			tmr_q <= '0;
			ptmr_q <= '0;
			lines_q <= 3'h0;
			tchan_q <= 3'h0;
			tmode_q <= 1'b0;
			adv_q <= 1'b0;
			skip_q <= 1'b0;
			conn_q <= 1'b0;
			nlr_q <= 1'b0;
			ien_q <= 1'b0;
			ovf_q <= 1'b0;
			par_q <= 1'b0;
			irq_q <= 1'b0;
			busy_q <= 1'b0;
			tres_q <= 1'b0;
			ham_q <= 1'b0;
			step_q <= 1'b0;
			ack_q <= 1'b0;
			rd_q <= 32'h0;
			chan_q <= LPCC_RST_CHAN;
			dev_q <= LPCC_RST_DEV;
			prcnt_q <= 16'h0;
		end
		else
		begin
			st_q <= st_d;
			ptr_q <= ptr_d;
			tmr_q <= tmr_d;
			ptmr_q <= ptmr_d;
			lines_q <= lines_d;
			tchan_q <= tchan_d;
			tmode_q <= tmode_d;
			adv_q <= adv_d;
			skip_q <= skip_d;
			conn_q <= conn_d;
			nlr_q <= nlr_d;
			ien_q <= ien_d;
			ovf_q <= ovf_d;
			par_q <= par_d;
			irq_q <= irq_d;
			busy_q <= busy_d;
			tres_q <= tres_d;
			ham_q <= ham_d;
			step_q <= step_d;
			ack_q <= ack_d;
			rd_q <= rd_d;
			chan_q <= chan_d;
			dev_q <= dev_d;
			prcnt_q <= prcnt_d;
		end
	end

	assign wb_dat_out      = rd_q;
	assign wb_ack_out      = ack_q;
	assign chan_parity_out = par_q;
	assign chan_irq_out    = irq_q;
	assign busy_out        = busy_q;
	assign test_result_out = tres_q;
	assign hammer_fire_out = ham_q;
	assign paper_step_out  = step_q;

endmodule

// ---- lpcc_ctrl_checker.sv ----
/*
 Concurrent checks on the line printer controller ports.
 Assumes one clock domain and a synchronous active high reset.
*/
`timescale 1ns/1ps
module lpcc_ctrl_checker
	import lpcc_pkg::*;
(
	// Clock and reset.
	input wire logic        clk_sys_in,
	input wire logic        rst_in,
	// Bus.
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [7:0]  wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic        wb_ack_out,
	// Status and mechanism.
	input wire logic        chan_parity_out,
	input wire logic        chan_irq_out,
	input wire logic        busy_out,
	input wire logic        test_result_out,
	input wire logic        hammer_fire_out,
	input wire logic        paper_step_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
		else $error("ack without request");
	a_dat_hold: assert property ($changed(wb_dat_out) |-> wb_ack_out)
		else $error("read data moved without ack");
	a_busy_cause: assert property ($changed(busy_out) |-> wb_ack_out && wb_we_in && wb_adr_in == LPCC_OFF_INSTR)
		else $error("busy moved without instruction");
	a_test_cause: assert property ($changed(test_result_out) |-> wb_ack_out && wb_dat_in[LPCC_INS_TEST_BIT])
		else $error("test result moved without test");
	a_parity_set: assert property ($rose(chan_parity_out) |-> wb_ack_out && wb_adr_in == LPCC_OFF_DATA)
		else $error("parity set without data");
	a_hammer_single: assert property (hammer_fire_out |=> !hammer_fire_out [*2])
		else $error("hammer pulses too close");
	a_step_gap: assert property (paper_step_out |=> !paper_step_out [*2])
		else $error("paper steps too close");
	a_irq_with_line: assert property (chan_irq_out |-> hammer_fire_out)
		else $error("interrupt without finished line");
	c_print: cover property (hammer_fire_out);
	c_busy: cover property ($rose(busy_out));
	c_step: cover property (paper_step_out);
endmodule

// ---- lpcc_mech_model.sv ----
/*
 Printer mechanism model: ready pin and an eight channel format tape.
 Assumes one paper step pulse per line moved.
*/
`timescale 1ns/1ps
module lpcc_mech_model
(
	// Clock and reset.
	input  wire logic       clk_sys_in,
	input  wire logic       rst_in,
	// Mechanism.
	input  wire logic       step_in,
	output logic            ready_out,
	output logic      [7:0] tape_out
);
	logic [2:0] pos_q;
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
			pos_q <= 3'h0;
		else if (step_in)
			pos_q <= pos_q + 3'h1;
	end
	// The printer stays ready throughout.
	assign ready_out = 1'b1;
	// Tape channel n is punched at line position n.
	assign tape_out = 8'h01 << pos_q;
endmodule

// ---- tb.sv ----
/*
 Testbench for the line printer controller: bus tasks and printing scenarios.
 Assumes the shortened step and print counts given to the design.
*/
`timescale 1ns/1ps
module tb
	import lpcc_pkg::*;
;
	logic        clk_sys_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        wb_cyc_in = 1'b0;
	logic        wb_stb_in = 1'b0;
	logic        wb_we_in = 1'b0;
	logic [7:0]  wb_adr_in = 8'h00;
	logic [3:0]  wb_sel_in = 4'h0;
	logic [31:0] wb_dat_in = 32'h0;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	logic        mech_ready_in;
	logic [7:0]  form_tape_in;
	logic        chan_parity_out;
	logic        chan_irq_out;
	logic        busy_out;
	logic        test_result_out;
	logic        hammer_fire_out;
	logic        paper_step_out;
	logic [31:0] rd;
	int          n_errors = 0;
	int          total_checks = 0;
	int          n_steps = 0;
	int          n_ham = 0;
	int          n_irq = 0;
	int          s0;
	int          st0;

	always #12.5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in)
	begin
		n_steps <= n_steps + int'(paper_step_out === 1'b1);
		n_ham <= n_ham + int'(hammer_fire_out === 1'b1);
		n_irq <= n_irq + int'(chan_irq_out === 1'b1);
	end

	lpcc_ctrl #(.STEP_CYCLES(4), .PRINT_CYCLES(8)) i_lpcc_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
		.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.mech_ready_in(mech_ready_in), .form_tape_in(form_tape_in), .other_connected_in(1'b0),
		.chan_parity_out(chan_parity_out), .chan_irq_out(chan_irq_out), .busy_out(busy_out),
		.test_result_out(test_result_out), .hammer_fire_out(hammer_fire_out), .paper_step_out(paper_step_out));
	lpcc_mech_model i_lpcc_mech_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .step_in(paper_step_out),
		.ready_out(mech_ready_in), .tape_out(form_tape_in));

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; entered just after a rising edge.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_sel_in <= 4'hf;
		wb_dat_in <= d;
		do
		begin
			@(posedge clk_sys_in);
		end
		while (wb_ack_out !== 1'b1);
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	// Sends one character with odd parity.
	task automatic ch(input logic [6:0] c);
		wb(1'b1, LPCC_OFF_DATA, {24'h0, ~^c, c});
	endtask

	task automatic wait_print();
		int n;
		n = 0;
		while (n_ham == s0 && n < 300)
		begin
			@(posedge clk_sys_in);
			n++;
		end
		chk(32'(n_ham - s0), 32'h1);
	endtask

	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		wb(1'b0, LPCC_OFF_CONFIG, 32'h0);
		chk(rd, 32'h01);
		wb(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, LPCC_OFF_INSTR, 32'h20204);
		chk(test_result_out, 1'b0);
		wb(1'b1, LPCC_OFF_INSTR, 32'h20104);
		chk(test_result_out, 1'b1);
		wb(1'b1, LPCC_OFF_INSTR, 32'h18000);
		wb(1'b0, LPCC_OFF_STATUS, 32'h0);
		chk(rd[1:0], 2'h3);
		wb(1'b1, LPCC_OFF_INSTR, 32'h08100);
		chk(busy_out, 1'b0);
		st0 = n_steps;
		ch(7'h12);
		wb(1'b1, LPCC_OFF_INSTR, 32'h0014a);
		chk(busy_out, 1'b1);
		ch(7'h21);
		wb(1'b1, LPCC_OFF_DATA, 32'h21);
		chk(chan_parity_out, 1'b1);
		ch(LPCC_EOL_CODE);
		s0 = n_ham;
		wait_print();
		chk(32'(n_steps - st0), 32'h2);
		wb(1'b0, LPCC_OFF_PRINTED, 32'h0);
		chk(rd, 32'h1);
		st0 = n_steps;
		wb(1'b1, LPCC_OFF_INSTR, 32'h00100);
		wb(1'b1, LPCC_OFF_INSTR, 32'h00180);
		chk(busy_out, 1'b1);
		ch(7'h12);
		ch(7'h41);
		ch(LPCC_EOL_CODE);
		s0 = n_ham;
		wait_print();
		chk(32'(n_steps - st0), 32'h0);
		wb(1'b0, LPCC_OFF_PRINTED, 32'h0);
		chk(rd, 32'h2);
		st0 = n_steps;
		s0 = n_ham;
		ch(7'h03);
		ch(LPCC_EOL_CODE);
		wb(1'b1, LPCC_OFF_INSTR, 32'h18000);
		wb(1'b1, LPCC_OFF_INSTR, 32'h00180);
		chk(busy_out, 1'b0);
		wb(1'b0, LPCC_OFF_STATUS, 32'h0);
		chk(rd[7:6], 2'h2);
		repeat (40) @(posedge clk_sys_in);
		chk(32'(n_steps - st0), 32'h1);
		chk(32'(n_ham - s0), 32'h1);
		chk(32'(n_irq), 32'h1);
		wb(1'b1, LPCC_OFF_INSTR, 32'h08100);
		wb(1'b0, LPCC_OFF_STATUS, 32'h0);
		chk(rd[7:6], 2'h1);
		report_and_stop();
	end

	initial
	begin
		repeat (3000) @(posedge clk_sys_in);
		n_errors++;
		report_and_stop();
	end
endmodule

bind lpcc_ctrl lpcc_ctrl_checker i_lpcc_ctrl_checker (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.chan_parity_out(chan_parity_out), .chan_irq_out(chan_irq_out), .busy_out(busy_out),
	.test_result_out(test_result_out),
	.hammer_fire_out(hammer_fire_out), .paper_step_out(paper_step_out));
